// ===== rtl/spm_pkg.sv
// package: register offsets, field positions, reset values and timing counts for the
// serial port master receive block. assumes an 8-bit plain register port.
package spm_pkg;
  localparam int          ADDR_W        = 3;
  localparam int          DATA_W        = 8;
  // register offsets
  localparam logic [2:0]  OFF_CTRL_TWO  = 3'h0;  // serial_control_two
  localparam logic [2:0]  OFF_CTRL_THR  = 3'h1;  // serial_control_three
  localparam logic [2:0]  OFF_STATUS    = 3'h2;  // sticky status, write one to clear; buffer-full cleared only by buffer read
  localparam logic [2:0]  OFF_MASK      = 3'h3;  // interrupt mask
  localparam logic [2:0]  OFF_BUF       = 3'h4;  // serial_data_buffer
  localparam logic [2:0]  OFF_BAUD      = 3'h5;  // baud reload
  // serial_control_two fields
  localparam int          C2_START      = 0;
  localparam int          C2_STOP       = 2;
  localparam int          C2_RCV        = 3;
  localparam int          C2_ACK_SEQUENCE_ENABLE      = 4;
  localparam int          C2_ACK_VALUE_TO_SEND      = 5;
  localparam int          C2_SLAVE_ACK_STATUS    = 6;
  // serial_control_three fields
  localparam int          C3_BUFFER_OVERWRITE_ENABLE       = 4;
  localparam int          C3_START_DETECT_IRQ_ENABLE       = 5;
  localparam int          C3_PCIE       = 6;
  localparam int          C3_ACK_TIME_STATUS     = 7;
  // status fields
  localparam int          ST_SIF        = 0;
  localparam int          ST_BF         = 1;
  localparam int          ST_OV         = 2;
  localparam int          ST_WRITE_COLLISION_FLAG       = 3;
  localparam int          ST_STARTDET   = 4;
  localparam int          ST_STOPDET    = 5;
  // reset values
  localparam logic [7:0]  RST_REG       = 8'h00;
  localparam logic [7:0]  RST_BAUD      = 8'h04;
  localparam logic [3:0]  RST_BITS      = 4'h0;
  localparam logic [3:0]  LAST_BIT      = 4'h8;  // ninth clock index
  localparam logic [3:0]  LAST_DATA     = 4'h7;
endpackage : spm_pkg

// ===== rtl/spm_baud.sv
// baud-rate generator: reload counter, pulses on rollover while running.
// assumes reload is stable while running.
module spm_baud (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [7:0] reload,
  output logic            roll
);
  logic [7:0] cnt_ff;

  // count down, reload on zero
  always_ff @(posedge mclk) begin
    if (!rst_n || !run) begin
      cnt_ff <= spm_pkg::RST_REG;
    end else if (cnt_ff == 8'h00) begin
      cnt_ff <= reload;
    end else begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

  assign roll = run && (cnt_ff == 8'h00);
endmodule // spm_baud

// ===== rtl/serial_port_master_receive.sv
// serial port master receive path: start, address out with ack sample,
// byte reception, master ack, status flags and interrupt.
// assumes scl and sda are open-drain pins resolved outside; inputs come from the pins.
// Function
// - receive-enable set while not idle is ignored.
// - each baud rollover toggles scl; each scl fall shifts one sda bit in.
// - after eighth fall clear enable, load buffer unless full with overwrite off, set flags, hold scl low.
// - buffer-full set on every shift-to-buffer transfer.
// - reading the buffer clears buffer-full.
// - byte completes while buffer-full set: set overflow.
// - buffer write during shifting sets collision, write dropped.
// - start request makes start condition, then sets interrupt flag.
// - buffer write of address starts shifting eight bits out.
// - sample slave ack into ack status bit.
// - interrupt flag at end of ninth address clock.
// - ack sequence clocks chosen ack out, then sets interrupt flag.
// - stop interrupt enable requests interrupt on detected stop.
module serial_port_master_receive (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_n,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic            irq
);
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_START = 6'b000010,
    ST_ADDR  = 6'b000100,
    ST_RECV  = 6'b001000,
    ST_ACK   = 6'b010000,
    ST_STOP  = 6'b100000
  } state_t;

  state_t     state_ff;
  logic [7:0] ctl2_ff, ctl3_ff, stat_ff, mask_ff, buf_ff, baud_ff, shift_ff;
  logic [3:0] bit_ff;
  logic [1:0] phase_ff;    // start/stop sub-steps
  logic       scl_ff, sda_ff;
  logic [1:0] scl_sy_ff, sda_sy_ff;
  logic       sda_prev_ff;
  logic       roll;
  logic       run;
  logic       wr_buf, rd_buf, wr_c2;
  logic       ev_sif, ev_bf, ev_ov, ev_write_collision_flag, ev_sdet, ev_pdet, ack_smp;
  logic [7:0] set_v, clr_v;

  assign wr_buf = wr && (addr == spm_pkg::OFF_BUF);
  assign rd_buf = rd && (addr == spm_pkg::OFF_BUF);
  assign wr_c2  = wr && (addr == spm_pkg::OFF_CTRL_TWO);
  assign run    = (state_ff != ST_IDLE);

  spm_baud u_baud (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .run    (run),
    .reload (baud_ff),
    .roll   (roll)
  );

  // pin synchronisers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_sy_ff   <= 2'h3;
      sda_sy_ff   <= 2'h3;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_sy_ff   <= {scl_sy_ff[0], scl_in};
      sda_sy_ff   <= {sda_sy_ff[0], sda_in};
      sda_prev_ff <= sda_sy_ff[1];
    end
  end

  // bus start/stop detection while scl high
  assign ev_sdet = scl_sy_ff[1] && sda_prev_ff && !sda_sy_ff[1];
  assign ev_pdet = scl_sy_ff[1] && !sda_prev_ff && sda_sy_ff[1];

  // main sequencer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      bit_ff   <= spm_pkg::RST_BITS;
      phase_ff <= 2'h0;
      scl_ff   <= 1'b1;
      sda_ff   <= 1'b1;
      shift_ff <= spm_pkg::RST_REG;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          bit_ff   <= spm_pkg::RST_BITS;
          phase_ff <= 2'h0;
          if (wr_c2 && wdata[spm_pkg::C2_START]) begin
            state_ff <= ST_START;
          end else if (wr_c2 && wdata[spm_pkg::C2_STOP]) begin
            state_ff <= ST_STOP;
          end else if (wr_c2 && wdata[spm_pkg::C2_RCV]) begin
            state_ff <= ST_RECV;
            sda_ff   <= 1'b1;  // release while scl is low, no false stop
          end else if (wr_c2 && wdata[spm_pkg::C2_ACK_SEQUENCE_ENABLE]) begin
            state_ff <= ST_ACK;
            sda_ff   <= wdata[spm_pkg::C2_ACK_VALUE_TO_SEND];
          end else if (wr_buf) begin
            state_ff <= ST_ADDR;
            shift_ff <= wdata;
            sda_ff   <= wdata[7];
          end
        end
        ST_START: if (roll) begin
          phase_ff <= phase_ff + 2'h1;
          if (phase_ff == 2'h0) sda_ff <= 1'b1;
          if (phase_ff == 2'h1) scl_ff <= 1'b1;
          if (phase_ff == 2'h2) sda_ff <= 1'b0;
          if (phase_ff == 2'h3) begin
            scl_ff   <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
        ST_STOP: if (roll) begin
          phase_ff <= phase_ff + 2'h1;
          if (phase_ff == 2'h0) sda_ff <= 1'b0;
          if (phase_ff == 2'h1) scl_ff <= 1'b1;
          if (phase_ff == 2'h2) begin
            sda_ff   <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        ST_ADDR: if (roll) begin
          scl_ff <= !scl_ff;
          if (scl_ff) begin
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == spm_pkg::LAST_BIT) begin
              state_ff <= ST_IDLE;
            end else begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              sda_ff   <= (bit_ff == spm_pkg::LAST_DATA) ? 1'b1 : shift_ff[6];
            end
          end
        end
        ST_RECV: if (roll) begin
          scl_ff <= !scl_ff;
          if (!scl_ff) begin
            sda_ff <= 1'b1;
          end else begin
            shift_ff <= {shift_ff[6:0], sda_sy_ff[1]};
            bit_ff   <= bit_ff + 4'h1;
            if (bit_ff == spm_pkg::LAST_DATA) state_ff <= ST_IDLE;
          end
        end
        ST_ACK: if (roll) begin
          scl_ff <= !scl_ff;
          if (scl_ff) state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // completion events
  assign ack_smp = (state_ff == ST_ADDR) && roll && scl_ff && (bit_ff == spm_pkg::LAST_BIT);
  assign ev_bf   = (state_ff == ST_RECV) && roll && scl_ff && (bit_ff == spm_pkg::LAST_DATA);
  assign ev_sif  = ack_smp || ev_bf
                || ((state_ff == ST_START) && roll && (phase_ff == 2'h3))
                || ((state_ff == ST_STOP) && roll && (phase_ff == 2'h2))
                || ((state_ff == ST_ACK) && roll && scl_ff);
  assign ev_ov   = ev_bf && stat_ff[spm_pkg::ST_BF];
  assign ev_write_collision_flag = wr_buf && (state_ff != ST_IDLE);

  // data buffer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      buf_ff <= spm_pkg::RST_REG;
    end else if (ev_bf && (!stat_ff[spm_pkg::ST_BF] || ctl3_ff[spm_pkg::C3_BUFFER_OVERWRITE_ENABLE])) begin
      buf_ff <= {shift_ff[6:0], sda_sy_ff[1]};
    end else if (wr_buf && (state_ff == ST_IDLE)) begin
      buf_ff <= wdata;
    end
  end

  // control registers; hardware clears receive and ack enables when done
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctl2_ff <= spm_pkg::RST_REG;
      ctl3_ff <= spm_pkg::RST_REG;
      mask_ff <= spm_pkg::RST_REG;
      baud_ff <= spm_pkg::RST_BAUD;
    end else begin
      if (wr_c2 && (state_ff == ST_IDLE)) begin
        ctl2_ff[5:0] <= wdata[5:0];
      end else if (state_ff == ST_IDLE) begin
        ctl2_ff[4:0] <= 5'h00;
      end
      if (ack_smp) ctl2_ff[spm_pkg::C2_SLAVE_ACK_STATUS] <= sda_sy_ff[1];
      if (wr && (addr == spm_pkg::OFF_CTRL_THR)) ctl3_ff[6:0] <= wdata[6:0];
      if (wr && (addr == spm_pkg::OFF_MASK)) mask_ff <= wdata;
      if (wr && (addr == spm_pkg::OFF_BAUD)) baud_ff <= wdata;
    end
  end

  // sticky status: set wins over clear, buffer-full cleared by buffer read
  always_comb begin
    set_v = 8'h00;
    set_v[spm_pkg::ST_SIF]      = ev_sif;
    set_v[spm_pkg::ST_BF]       = ev_bf;
    set_v[spm_pkg::ST_OV]       = ev_ov;
    set_v[spm_pkg::ST_WRITE_COLLISION_FLAG]     = ev_write_collision_flag;
    set_v[spm_pkg::ST_STARTDET] = ev_sdet && ctl3_ff[spm_pkg::C3_START_DETECT_IRQ_ENABLE];
    set_v[spm_pkg::ST_STOPDET]  = ev_pdet && ctl3_ff[spm_pkg::C3_PCIE];
    clr_v = (wr && (addr == spm_pkg::OFF_STATUS)) ? wdata : 8'h00;
    clr_v[spm_pkg::ST_BF] = rd_buf;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stat_ff <= spm_pkg::RST_REG;
    end else begin
      stat_ff <= (stat_ff & ~clr_v) | set_v;
    end
  end

  // read port
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= spm_pkg::RST_REG;
    end else if (rd) begin
      unique case (addr)
        spm_pkg::OFF_CTRL_TWO: rdata <= ctl2_ff;
        spm_pkg::OFF_CTRL_THR: rdata <= ctl3_ff;
        spm_pkg::OFF_STATUS:   rdata <= stat_ff;
        spm_pkg::OFF_MASK:     rdata <= mask_ff;
        spm_pkg::OFF_BUF:      rdata <= buf_ff;
        spm_pkg::OFF_BAUD:     rdata <= baud_ff;
        default:               rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // open-drain pins: enable low drives a zero
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = scl_ff;
  assign sda_oe_n = sda_ff;
  assign irq      = |(stat_ff & mask_ff & 8'h3d);

  // checks
  baud_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_ff == ST_RECV) && !roll |=> $stable(scl_ff))
    else $error("scl moved without rollover");
  recv_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ev_bf |=> stat_ff[spm_pkg::ST_BF] && stat_ff[spm_pkg::ST_SIF] && !scl_ff)
    else $error("receive completion flags wrong");
  bf_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_buf && !ev_bf |=> !stat_ff[spm_pkg::ST_BF])
    else $error("buffer-full not cleared by read");
  ovf_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ev_bf && stat_ff[spm_pkg::ST_BF] |=> stat_ff[spm_pkg::ST_OV])
    else $error("overflow not flagged");
  write_collision_flag_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ev_write_collision_flag |=> stat_ff[spm_pkg::ST_WRITE_COLLISION_FLAG] && $stable(buf_ff))
    else $error("collision write altered buffer");
  rcv_ignore_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_c2 && (state_ff == ST_ADDR) && !roll |=> state_ff == ST_ADDR)
    else $error("busy request accepted");
  slave_ack_status_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ack_smp |=> ctl2_ff[spm_pkg::C2_SLAVE_ACK_STATUS] == $past(sda_sy_ff[1]))
    else $error("ack status not stored");
  keep_old_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ev_ov && !ctl3_ff[spm_pkg::C3_BUFFER_OVERWRITE_ENABLE] |=> $stable(buf_ff))
    else $error("buffer overwritten");
  start_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ev_sdet && !ctl3_ff[spm_pkg::C3_START_DETECT_IRQ_ENABLE] && !stat_ff[spm_pkg::ST_STARTDET]
    |=> !stat_ff[spm_pkg::ST_STARTDET])
    else $error("start detect flagged while disabled");
  recv_cov: cover property (@(posedge mclk) disable iff (!rst_n) ev_bf);
  addr_cov: cover property (@(posedge mclk) disable iff (!rst_n) ack_smp);
  ovf_cov:  cover property (@(posedge mclk) disable iff (!rst_n) ev_ov);
endmodule // serial_port_master_receive

// ===== tb/i2c_slave_model.sv
// behavioural slave on the shared bus: takes the address, acks it, then on a read
// sends bytes byte0, byte0+step, ... until the master answers with a not-acknowledge.
// assumes both lines have pull-ups and that scl is never stretched here.
module i2c_slave_model #(
  parameter logic [7:0] BYTE0 = 8'h5c,
  parameter logic [7:0] STEP  = 8'h11
) (
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_oe_n,
  output logic      [7:0] addr_seen,
  output logic            master_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic [7:0] tx;
  int         bitn;
  logic       active;
  logic       reading;

  initial begin
    sda_oe_n = 1'b1;
    addr_seen = 8'h00;
    master_ack = 1'b1;
    active = 1'b0;
    reading = 1'b0;
    tx = BYTE0;
    bitn = 0;
    sh = 8'h00;
  end

  // start and stop are seen as sda edges while scl is high
  always @(negedge sda) if (scl === 1'b1) begin
    active = 1'b1;
    reading = 1'b0;
    bitn = -1;  // the start's own scl fall must not count as a bit
  end
  always @(posedge sda) if (scl === 1'b1) begin
    active = 1'b0;
    sda_oe_n = 1'b1;
  end

  // rising scl samples the line: data bits, then the master's answer on a read
  always @(posedge scl) if (active) begin
    if (bitn < 8) sh = {sh[6:0], sda};  // msb first
    else if (reading) master_ack = sda;
  end

  // falling scl moves the slave on; the line only changes while scl is low
  always @(negedge scl) if (active) begin
    bitn = bitn + 1;
    if (bitn == 8) begin
      if (!reading) addr_seen = sh;
      sda_oe_n = reading;  // ack the address, release for the master's answer
    end else if (bitn == 9) begin
      bitn = 0;
      if (!reading) begin
        reading = addr_seen[0];
        sda_oe_n = reading ? tx[7] : 1'b1;
      end else if (!master_ack) begin
        tx = tx + STEP;
        sda_oe_n = tx[7];
      end else begin
        active = 1'b0;  // not-acknowledge ends the read
        sda_oe_n = 1'b1;
      end
    end else if (reading) sda_oe_n = tx[7-bitn];
  end
endmodule // i2c_slave_model

// ===== tb/serial_port_master_receive_tb_top.sv
// self-checking bench: register port tasks, one task per receive scenario.
// assumes open-drain lines with pull-ups; sda resolved here from both parties' enables, scl from the master's alone.
module serial_port_master_receive_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] B0 = 8'h5c;
  localparam logic [7:0] ST = 8'h11;
  logic       mclk   = 1'b0;
  logic       rst_n  = 1'b0;
  logic [2:0] addr   = 3'h0;
  logic [7:0] wdata  = 8'h00;
  logic       wr     = 1'b0;
  logic       rd     = 1'b0;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [7:0] aseen;
  logic       scl_out;
  logic       scl_oe_n;
  logic       sda_out;
  logic       sda_oe_n;
  logic       irq;
  logic       s_oe_n;
  logic       mack;
  wire        scl    = scl_oe_n;
  wire        sda    = sda_oe_n & s_oe_n;
  int         n_fail = 0;
  int         n_compared = 0;

  always #5 mclk = ~mclk;

  serial_port_master_receive uut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
  i2c_slave_model #(.BYTE0(B0), .STEP(ST)) slave (.scl(scl), .sda(sda), .sda_oe_n(s_oe_n),
    .addr_seen(aseen), .master_ack(mack));

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle strobes, changed right after the edge
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_stat(input int b);
    for (int i = 0; i < 300; i++) begin
      rd_reg(spm_pkg::OFF_STATUS, v);
      if (v[b] === 1'b1) return;
    end
    n_fail++;
    $display("wrong value at %0t: status bit %0d never set", $time, b);
    give_verdict();
  endtask

  // issue a command, wait for its flag, clear the flag
  task automatic cmd(input logic [7:0] c, input int b);
    wr_reg(spm_pkg::OFF_CTRL_TWO, c);
    wait_stat(b);
    wr_reg(spm_pkg::OFF_STATUS, 8'h01 << b);
  endtask

  task automatic t_reset();
    chk({7'h0, irq}, 8'h00);
    for (int a = 0; a < 8; a++) begin
      rd_reg(3'(a), v);
      chk(v, (a == 5) ? spm_pkg::RST_BAUD : 8'h00);
    end
    wr_reg(spm_pkg::OFF_BAUD, 8'h03);
    rd_reg(spm_pkg::OFF_BAUD, v);
    chk(v, 8'h03);
  endtask

  task automatic t_start();
    wr_reg(spm_pkg::OFF_MASK, 8'h3d);
    wr_reg(spm_pkg::OFF_CTRL_TWO, 8'h01);
    wait_stat(spm_pkg::ST_SIF);
    chk(v & 8'h11, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr_reg(spm_pkg::OFF_MASK, 8'h00);
    rd_reg(spm_pkg::OFF_MASK, v);
    chk({7'h0, irq}, 8'h00);
    wr_reg(spm_pkg::OFF_MASK, 8'h3d);
    rd_reg(spm_pkg::OFF_MASK, v);
    chk({7'h0, irq}, 8'h01);
    wr_reg(spm_pkg::OFF_STATUS, 8'h01);
    rd_reg(spm_pkg::OFF_STATUS, v);
    chk({7'h0, irq}, 8'h00);
  endtask

  task automatic t_addr();
    wr_reg(spm_pkg::OFF_BUF, 8'ha3);
    wr_reg(spm_pkg::OFF_BUF, 8'h77);  // lands while the address shifts
    wr_reg(spm_pkg::OFF_CTRL_TWO, 8'h08);  // busy, so dropped
    wait_stat(spm_pkg::ST_SIF);
    chk(v & 8'h09, 8'h09);
    chk(aseen, 8'ha3);
    rd_reg(spm_pkg::OFF_CTRL_TWO, v);
    chk(v, 8'h00);
    rd_reg(spm_pkg::OFF_BUF, v);
    wr_reg(spm_pkg::OFF_STATUS, 8'h01);
    rd_reg(spm_pkg::OFF_STATUS, v);
    chk(v & 8'h08, 8'h08);
    wr_reg(spm_pkg::OFF_STATUS, 8'h08);
    rd_reg(spm_pkg::OFF_STATUS, v);
    chk(v, 8'h00);
  endtask

  task automatic t_recv();
    wr_reg(spm_pkg::OFF_CTRL_TWO, 8'h08);
    wait_stat(spm_pkg::ST_SIF);
    chk(v & 8'h06, 8'h02);
    chk({7'h0, scl_oe_n}, 8'h00);
    rd_reg(spm_pkg::OFF_CTRL_TWO, v);
    chk(v & 8'h08, 8'h00);
    rd_reg(spm_pkg::OFF_BUF, v);
    chk(v, B0);
    rd_reg(spm_pkg::OFF_STATUS, v);
    chk(v & 8'h02, 8'h00);
    wr_reg(spm_pkg::OFF_STATUS, 8'h01);
    cmd(8'h10, spm_pkg::ST_SIF);
    chk({7'h0, mack}, 8'h00);
  endtask

  // second byte arrives on a full buffer, overwrite off
  task automatic t_ovf();
    cmd(8'h08, spm_pkg::ST_SIF);
    cmd(8'h10, spm_pkg::ST_SIF);
    cmd(8'h08, spm_pkg::ST_SIF);
    rd_reg(spm_pkg::OFF_STATUS, v);
    chk(v & 8'h06, 8'h06);
    rd_reg(spm_pkg::OFF_BUF, v);
    chk(v, B0 + ST);
    wr_reg(spm_pkg::OFF_STATUS, 8'h01);
    rd_reg(spm_pkg::OFF_STATUS, v);
    chk(v & 8'h04, 8'h04);
    wr_reg(spm_pkg::OFF_STATUS, 8'h04);
  endtask

  // overwrite on, then not-acknowledge and stop
  task automatic t_ovw();
    wr_reg(spm_pkg::OFF_CTRL_THR, 8'h50);
    rd_reg(spm_pkg::OFF_CTRL_THR, v);
    chk(v, 8'h50);
    cmd(8'h10, spm_pkg::ST_SIF);
    cmd(8'h08, spm_pkg::ST_SIF);
    cmd(8'h10, spm_pkg::ST_SIF);
    cmd(8'h08, spm_pkg::ST_SIF);
    rd_reg(spm_pkg::OFF_STATUS, v);
    chk(v & 8'h06, 8'h06);
    rd_reg(spm_pkg::OFF_BUF, v);
    chk(v, B0 + 8'h44);
    wr_reg(spm_pkg::OFF_STATUS, 8'h04);
    cmd(8'h30, spm_pkg::ST_SIF);
    chk({7'h0, mack}, 8'h01);
    wr_reg(spm_pkg::OFF_CTRL_TWO, 8'h04);
    wait_stat(spm_pkg::ST_STOPDET);
    chk({7'h0, irq}, 8'h01);
    wr_reg(spm_pkg::OFF_STATUS, 8'h3f);
  endtask

  task automatic t_restart();
    wr_reg(spm_pkg::OFF_CTRL_THR, 8'h70);
    wr_reg(spm_pkg::OFF_CTRL_TWO, 8'h01);
    wait_stat(spm_pkg::ST_SIF);
    chk(v & 8'h10, 8'h10);
    wr_reg(spm_pkg::OFF_STATUS, 8'h11);
    wr_reg(spm_pkg::OFF_CTRL_TWO, 8'h04);
    wait_stat(spm_pkg::ST_STOPDET);
    wr_reg(spm_pkg::OFF_STATUS, 8'h3f);
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_start();
    t_addr();
    t_recv();
    t_ovf();
    t_ovw();
    t_restart();
    give_verdict();
  end
endmodule // serial_port_master_receive_tb_top
